// [nfm_mixer_cfg.v]
// Purpose: ahb-lite register bank and two fine mixer ncos
// Assumes: single word transfers, response always okay, zero wait states
// Notes:   the write lands one edge after the address phase edge
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "nfm_regs.vh"
module nfm_mixer_cfg
(
  // ahb-lite clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // mixer address outputs
  output wire [15:0] ab_table_addr,
  output wire [15:0] cd_table_addr,
  output wire [31:0] ab_phase_acc,
  output wire [31:0] cd_phase_acc,
  // sync event pulses
  output reg         ab_sync_r,
  output reg         cd_sync_r
);

  // ****************************************
  // address phase capture
  // ****************************************
  reg        wr_pend_r;
  reg [5:0]  wr_idx_r;

  function [5:0] word_idx;
    input [31:0] a;
    begin
      word_idx = a[7:2];
    end
  endfunction

  wire ap_valid = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 6'h00;
    end
    else
    begin
      wr_pend_r <= ap_valid & hwrite;
      wr_idx_r  <= word_idx(haddr);
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ****************************************
  // staged registers
  // ****************************************
  reg [15:0] ab_pair_phase_shift_r;
  reg [15:0] cd_mixer_phase_offset_r;
  reg [15:0] ab_mixer_freq_low_r;
  reg [15:0] ab_mixer_freq_high_r;
  reg [15:0] cd_mixer_freq_low_r;
  reg [15:0] cd_mixer_freq_high_r;
  reg [1:0]  sync_control_register_r;

  wire [15:0] wd = hwdata[15:0];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ab_pair_phase_shift_r   <= `NFM_RST_HALF;
      cd_mixer_phase_offset_r <= `NFM_RST_HALF;
      ab_mixer_freq_low_r     <= `NFM_RST_HALF;
      ab_mixer_freq_high_r    <= `NFM_RST_HALF;
      cd_mixer_freq_low_r     <= `NFM_RST_HALF;
      cd_mixer_freq_high_r    <= `NFM_RST_HALF;
      sync_control_register_r <= `NFM_RST_SYNC;
      ab_sync_r               <= 1'b0;
      cd_sync_r               <= 1'b0;
    end
    else
    begin
      ab_sync_r <= 1'b0;
      cd_sync_r <= 1'b0;
      if (wr_pend_r)
      begin
        case (wr_idx_r)
          `NFM_IDX_AB_PHASE:
          begin
            ab_pair_phase_shift_r <= wd;
            ab_sync_r <= sync_control_register_r[`NFM_SYNC_AUTO_BIT];
          end
          `NFM_IDX_CD_PHASE:
          begin
            cd_mixer_phase_offset_r <= wd;
            cd_sync_r <= sync_control_register_r[`NFM_SYNC_AUTO_BIT];
          end
          `NFM_IDX_AB_FREQ_LO: ab_mixer_freq_low_r  <= wd;
          `NFM_IDX_AB_FREQ_HI: ab_mixer_freq_high_r <= wd;
          `NFM_IDX_CD_FREQ_LO: cd_mixer_freq_low_r  <= wd;
          `NFM_IDX_CD_FREQ_HI: cd_mixer_freq_high_r <= wd;
          `NFM_IDX_SYNC_CTRL:
          begin
            // manual bit is self clearing; it syncs both pairs at once
            sync_control_register_r[`NFM_SYNC_AUTO_BIT] <=
              hwdata[`NFM_SYNC_AUTO_BIT];
            ab_sync_r <= hwdata[`NFM_SYNC_MANUAL_BIT];
            cd_sync_r <= hwdata[`NFM_SYNC_MANUAL_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // read data
  // ****************************************
  reg [31:0] rd_nxt;

  always @*
  begin
    rd_nxt = 32'h00000000;
    case (word_idx(haddr))
      `NFM_IDX_AB_PHASE:   rd_nxt = {16'h0000, ab_pair_phase_shift_r};
      `NFM_IDX_CD_PHASE:   rd_nxt = {16'h0000, cd_mixer_phase_offset_r};
      `NFM_IDX_AB_FREQ_LO: rd_nxt = {16'h0000, ab_mixer_freq_low_r};
      `NFM_IDX_AB_FREQ_HI: rd_nxt = {16'h0000, ab_mixer_freq_high_r};
      `NFM_IDX_CD_FREQ_LO: rd_nxt = {16'h0000, cd_mixer_freq_low_r};
      `NFM_IDX_CD_FREQ_HI: rd_nxt = {16'h0000, cd_mixer_freq_high_r};
      `NFM_IDX_SYNC_CTRL:  rd_nxt = {30'h0,
                                     1'b0,
                                     sync_control_register_r[0]};
      default:             rd_nxt = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (ap_valid & ~hwrite)
      hrdata <= rd_nxt;
  end

  // ****************************************
  // active settings and ncos
  // ****************************************
  wire [31:0] ab_pair_freq_word;
  wire [31:0] cd_pair_freq_word;
  wire [15:0] ab_phase_act;
  wire [15:0] cd_pair_phase_shift;

  nfm_pair_shadow u_ab_shadow
  (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .load        (ab_sync_r),
    .freq_stage  ({ab_mixer_freq_high_r, ab_mixer_freq_low_r}),
    .phase_stage (ab_pair_phase_shift_r),
    .freq_act_r  (ab_pair_freq_word),
    .phase_act_r (ab_phase_act)
  );

  nfm_pair_shadow u_cd_shadow
  (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .load        (cd_sync_r),
    .freq_stage  ({cd_mixer_freq_high_r, cd_mixer_freq_low_r}),
    .phase_stage (cd_mixer_phase_offset_r),
    .freq_act_r  (cd_pair_freq_word),
    .phase_act_r (cd_pair_phase_shift)
  );

  nfm_nco u_ab_nco
  (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .freq_word    (ab_pair_freq_word),
    .phase_shift  (ab_phase_act),
    .restart      (1'b0),
    .acc_r        (ab_phase_acc),
    .table_addr_r (ab_table_addr)
  );

  nfm_nco u_cd_nco
  (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .freq_word    (cd_pair_freq_word),
    .phase_shift  (cd_pair_phase_shift),
    .restart      (1'b0),
    .acc_r        (cd_phase_acc),
    .table_addr_r (cd_table_addr)
  );

endmodule
`default_nettype wire

// [nfm_regs.vh]
// Purpose: constants for the fine mixer nco configuration bank
// Assumes: ahb-lite slave, 32-bit words, one register per aligned word
// Notes:   printed offsets are word indices; byte address is index * 4
//
// Notes on behaviour
// - frequency word is signed two's complement; negative values run backwards.
// - one lsb of frequency word steps fs divided by two to the 32.
// - ab frequency word: low half at 0x14, high half at 0x15.
// - cd frequency word: low half at 0x16, high half at 0x17.
// - cd phase offset added to cd accumulator before sine/cosine generation.
// - offset sums into upper 16 accumulator bits; that sum addresses tables.
// - with auto-sync on, cd offset write loads cd offset and frequency together.
// - cd frequency writes alone leave the mixer unchanged; write offset last.
// - all offset and frequency registers reset to zero.
// - ab pair has own 16-bit phase offset at 0x12, added likewise.
// - with auto-sync on, ab offset write loads ab offset and frequency together.
`ifndef NFM_REGS_VH
`define NFM_REGS_VH

// ****************************************
// register indices
// ****************************************
`define NFM_IDX_AB_PHASE     6'h12
`define NFM_IDX_CD_PHASE     6'h13
`define NFM_IDX_AB_FREQ_LO   6'h14
`define NFM_IDX_AB_FREQ_HI   6'h15
`define NFM_IDX_CD_FREQ_LO   6'h16
`define NFM_IDX_CD_FREQ_HI   6'h17
`define NFM_IDX_SYNC_CTRL    6'h1F

// ****************************************
// fields and reset values
// ****************************************
`define NFM_SYNC_AUTO_BIT    0
`define NFM_SYNC_MANUAL_BIT  1
`define NFM_RST_HALF         16'h0000
`define NFM_RST_SYNC         2'h1
`define NFM_ACC_W            32
`define NFM_PHASE_W          16

`endif

// [nfm_nco.v]
// Purpose: one nco: accumulator plus phase offset giving table address
// Assumes: runs every hclk, settings already synchronised
// Notes:   table itself lives downstream; this only forms the address
`timescale 1ns/1ns
`default_nettype none
`include "nfm_regs.vh"
module nfm_nco
(
  // clock and reset
  input  wire                        hclk,
  input  wire                        hresetn,
  // active settings
  input  wire [`NFM_ACC_W-1:0]       freq_word,
  input  wire [`NFM_PHASE_W-1:0]     phase_shift,
  input  wire                        restart,
  // outputs
  output reg  [`NFM_ACC_W-1:0]       acc_r,
  output reg  [`NFM_PHASE_W-1:0]     table_addr_r
);

  // ****************************************
  // accumulator
  // ****************************************
  // signed word added modulo 2^32 wraps both ways for free
  wire [`NFM_ACC_W-1:0] acc_nxt = acc_r + freq_word;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acc_r        <= 32'h00000000;
      table_addr_r <= 16'h0000;
    end
    else
    begin
      if (restart)
        acc_r <= 32'h00000000;
      else
        acc_r <= acc_nxt;
      // only the top 16 bits reach the tables
      table_addr_r <= acc_r[`NFM_ACC_W-1:`NFM_ACC_W-`NFM_PHASE_W]
                      + phase_shift;
    end
  end

endmodule
`default_nettype wire

// [nfm_pair_shadow.v]
// Purpose: holds one pair's active mixer settings, loaded on sync
// Assumes: load is a one-cycle pulse from the register block
// Notes:   staged writes never reach the nco until a load
`timescale 1ns/1ns
`default_nettype none
`include "nfm_regs.vh"
module nfm_pair_shadow
(
  // clock and reset
  input  wire                        hclk,
  input  wire                        hresetn,
  // staged values
  input  wire                        load,
  input  wire [`NFM_ACC_W-1:0]       freq_stage,
  input  wire [`NFM_PHASE_W-1:0]     phase_stage,
  // active values
  output reg  [`NFM_ACC_W-1:0]       freq_act_r,
  output reg  [`NFM_PHASE_W-1:0]     phase_act_r
);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      freq_act_r  <= 32'h00000000;
      phase_act_r <= 16'h0000;
    end
    else if (load)
    begin
      // all three halves move in one edge
      freq_act_r  <= freq_stage;
      phase_act_r <= phase_stage;
    end
  end

endmodule
`default_nettype wire

// [nfm_checker.sv]
// Purpose: port checks for the mixer config bank
// Assumes: register index decoded from haddr[7:2]
// Notes:   offsets seen only as table address minus acc
`timescale 1ns/1ns
`default_nettype none
`include "nfm_regs.vh"
module nfm_checker
(
  // bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // mixer
  input wire logic [15:0] ab_table_addr,
  input wire logic [15:0] cd_table_addr,
  input wire logic [31:0] ab_phase_acc,
  input wire logic [31:0] cd_phase_acc,
  input wire logic        ab_sync_r,
  input wire logic        cd_sync_r
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire tk = hsel && hready && htrans[1];
  // a load shifts step and offset, so its cycle and the two after it are skipped
  sequence s_abq;
    !ab_sync_r && !$past(ab_sync_r) && !$past(ab_sync_r, 2);
  endsequence
  sequence s_cdq;
    !cd_sync_r && !$past(cd_sync_r) && !$past(cd_sync_r, 2);
  endsequence
  property p_acc_ab;
    s_abq |-> ab_phase_acc - $past(ab_phase_acc)
      == $past(ab_phase_acc) - $past(ab_phase_acc, 2);
  endproperty
  a_acc_ab: assert property (p_acc_ab)
    else $error("ab step moved");
  property p_acc_cd;
    s_cdq |-> cd_phase_acc - $past(cd_phase_acc)
      == $past(cd_phase_acc) - $past(cd_phase_acc, 2);
  endproperty
  a_acc_cd: assert property (p_acc_cd)
    else $error("cd step moved");
  property p_ofs_ab;
    s_abq |-> ab_table_addr - $past(ab_phase_acc[31:16])
      == $past(ab_table_addr) - $past(ab_phase_acc[31:16], 2);
  endproperty
  a_ofs_ab: assert property (p_ofs_ab)
    else $error("ab offset moved");
  property p_ofs_cd;
    s_cdq |-> cd_table_addr - $past(cd_phase_acc[31:16])
      == $past(cd_table_addr) - $past(cd_phase_acc[31:16], 2);
  endproperty
  a_ofs_cd: assert property (p_ofs_cd)
    else $error("cd offset moved");
  property p_src_cd;
    $rose(cd_sync_r) |-> $past(tk && hwrite, 2) && $past(haddr[7:2], 2)
      inside {`NFM_IDX_CD_PHASE, `NFM_IDX_SYNC_CTRL};
  endproperty
  a_src_cd: assert property (p_src_cd)
    else $error("cd sync without cause");
  property p_src_ab;
    $rose(ab_sync_r) |-> $past(tk && hwrite, 2) && $past(haddr[7:2], 2)
      inside {`NFM_IDX_AB_PHASE, `NFM_IDX_SYNC_CTRL};
  endproperty
  a_src_ab: assert property (p_src_ab)
    else $error("ab sync without cause");
  property p_rd_hi;
    tk && !hwrite |=> hrdata[31:16] == 16'h0000;
  endproperty
  a_rd_hi: assert property (p_rd_hi)
    else $error("upper read bits set");
  property p_bus;
    hreadyout && !hresp;
  endproperty
  a_bus: assert property (p_bus)
    else $error("wait or error on bus");
  c_cd: cover property (cd_sync_r);
  c_ab: cover property (ab_sync_r);
  c_rd: cover property (tk && !hwrite);
endmodule
bind nfm_mixer_cfg nfm_checker i_nfm_checker (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .ab_table_addr, .cd_table_addr, .ab_phase_acc, .cd_phase_acc,
  .ab_sync_r, .cd_sync_r);
`default_nettype wire

// [nfm_mixer_cfg_tb.sv]
// Purpose: directed bench for the mixer config bank
// Assumes: sync control at index 0x1F, auto-sync on after reset
// Notes:   nco steps are measured at the outputs, not read back
`timescale 1ns/1ns
`default_nettype none
`include "nfm_regs.vh"
module nfm_mixer_cfg_tb;
  // ********
  // bench
  // ********
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b1;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  wire  [31:0] hrdata, ab_phase_acc, cd_phase_acc;
  wire  [15:0] ab_table_addr, cd_table_addr;
  wire         hreadyout, hresp, ab_sync_r, cd_sync_r;
  int          error_cnt = 0;
  int          n_tests = 0;
  always #5 hclk = ~hclk;
  nfm_mixer_cfg i_nfm_mixer_cfg (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata,
    .hreadyout, .hresp, .ab_table_addr, .cd_table_addr, .ab_phase_acc,
    .cd_phase_acc, .ab_sync_r, .cd_sync_r);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic conclude;
    $display("checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // bounded wait for hready; a hang ends the run
  task automatic wt;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      chk(32'h0, 32'h1);
      conclude;
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] i,
                     input logic [31:0] d, output logic [31:0] r);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, i, 2'h0};
    wt;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    r = hrdata;
  endtask
  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, i, d, r);
  endtask
  // step per clock and table address one cycle behind the acc
  task automatic dlt(input logic cd, input logic [31:0] e,
                     input logic [15:0] o);
    logic [31:0] a;
    repeat (3) @(posedge hclk);
    #1;
    a = cd ? cd_phase_acc : ab_phase_acc;
    @(posedge hclk);
    #1;
    chk((cd ? cd_phase_acc : ab_phase_acc) - a, e);
    chk(cd ? cd_table_addr : ab_table_addr, 16'(a[31:16] + o));
  endtask
  task automatic t_reset;
    logic [31:0] r;
    for (int i = 18; i < 24; i++)
    begin
      bus(1'b0, 6'(i), 32'h0, r);
      chk(r, 32'h0);
    end
    bus(1'b0, 6'h00, 32'h0, r);
    chk(r, 32'h0);
    bus(1'b0, `NFM_IDX_SYNC_CTRL, 32'h0, r);
    chk(r, 32'h1);
  endtask
  task automatic t_cd;
    logic [31:0] r;
    wr(`NFM_IDX_CD_FREQ_LO, 32'h0000FFFE);
    wr(`NFM_IDX_CD_FREQ_HI, 32'h0000FFFF);
    bus(1'b0, `NFM_IDX_CD_FREQ_HI, 32'h0, r);
    chk(r, 32'h0000FFFF);
    dlt(1'b1, 32'h0, 16'h0);
    wr(`NFM_IDX_CD_PHASE, 32'h00001234);
    #1;
    chk(cd_sync_r, 1'b1);
    dlt(1'b1, 32'hFFFFFFFE, 16'h1234);
  endtask
  task automatic t_ab;
    wr(`NFM_IDX_SYNC_CTRL, 32'h0);
    wr(`NFM_IDX_AB_FREQ_LO, 32'h00000003);
    wr(`NFM_IDX_AB_FREQ_HI, 32'h00000001);
    wr(`NFM_IDX_AB_PHASE, 32'h00008000);
    #1;
    chk(ab_sync_r, 1'b0);
    dlt(1'b0, 32'h0, 16'h0);
    wr(`NFM_IDX_SYNC_CTRL, 32'h2);
    dlt(1'b0, 32'h00010003, 16'h8000);
  endtask
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_cd;
    t_ab;
    conclude;
  end
endmodule
`default_nettype wire
